//--- pkg/dbl_pkg.sv
`default_nettype none
package dbl_pkg;
    // ***************************************************************
    // register map geometry
    // ***************************************************************
    localparam int unsigned DATA_W = 10; // every register is ten bits wide
    localparam int unsigned ADDR_W = 5; // address field of the register port
    localparam logic [4:0] ADDR_NOP = 5'h00;
    localparam logic [4:0] ADDR_CH1_PEAK = 5'h01;
    localparam logic [4:0] ADDR_CH2_PEAK = 5'h02;
    localparam logic [4:0] ADDR_OFF_TIME = 5'h03;
    localparam logic [4:0] ADDR_REG_CTRL = 5'h04;
    localparam logic [4:0] ADDR_THERMAL = 5'h05;
    localparam logic [4:0] ADDR_LED_MEAS = 5'h06;
    localparam logic [4:0] ADDR_CH1_TRIM = 5'h07;
    localparam logic [4:0] ADDR_CH2_TRIM = 5'h08;
    localparam logic [4:0] ADDR_ADC_OTP = 5'h09;
    localparam logic [4:0] ADDR_CH1_VLED = 5'h0a;
    localparam logic [4:0] ADDR_CH2_VLED = 5'h0b;
    // ***************************************************************
    // reset values
    // ***************************************************************
    localparam logic [9:0] RST_ZERO = 10'h000;
    localparam logic [9:0] RST_THERMAL = 10'h0b3;
    localparam logic [9:0] RST_VLED = 10'h100;
    localparam logic [7:0] RST_SAMPLE = 8'h00;
    // ***************************************************************
    // field positions
    // ***************************************************************
    localparam int unsigned PEAK_RANGE_LSB = 8; // range select at [9:8]
    localparam int unsigned TOFF1_LSB = 5; // channel one off-time at [9:5]
    localparam int unsigned CTRL_OCD_LSB = 5; // overcurrent setting at [6:5]
    localparam int unsigned CTRL_FSO_LSB = 2; // fail-safe mode at [4:2]
    localparam int unsigned CTRL_SLOW_BIT = 7;
    localparam int unsigned CTRL_OC1_BIT = 9;
    localparam int unsigned CTRL_OC2_BIT = 8;
    localparam int unsigned CTRL_EN1_BIT = 1;
    localparam int unsigned CTRL_EN2_BIT = 0;
    localparam int unsigned THERM_AR1_BIT = 9;
    localparam int unsigned THERM_AR2_BIT = 8;
    localparam int unsigned PARITY_BIT = 8; // odd parity bit of status words
    localparam int unsigned TRIM_HI_LSB = 7; // temperature trim slice at [9:7]
    localparam int unsigned ADC1_RNG_LSB = 8;
    localparam int unsigned ADC2_RNG_LSB = 6;
endpackage
`default_nettype wire

//--- hdl/dbl_config_regs.sv
// What this block does
// - address zero ignores writes and reads nothing
// - peak register top bits pick current range
// - peak register low byte sets comparator threshold
// - off-time register holds two five-bit constants
// - control bits one, zero enable regulators
// - control bits nine, eight disable offset cancel
// - control holds slope, overcurrent, fail-safe fields
// - thermal bits nine, eight enable auto recovery
// - thermal low byte warning threshold, reset 0b3
// - measure setting low nine bits, trim parity
// - trim registers hold compensation and temperature trim
// - register nine holds two adc range selects
// - status bit eight gives odd parity
// - status registers return latest adc sample
// - status reset reads bit eight only set
`timescale 1ns/1ns
`default_nettype none
module dbl_config_regs (
    input wire logic clk,
    input wire logic rst,
    // register port from the serial front end; each strobe stands one cycle
    // and carries exactly one ten-bit word, so there is no burst state here
    input wire logic reg_wr, // one-cycle write strobe from the serial front end
    input wire logic reg_rd, // one-cycle read strobe
    // address and data only matter while a strobe is high
    input wire logic [4:0] reg_addr,
    input wire logic [9:0] reg_wdata,
    // answer side: word and marker both come from flops
    output logic [9:0] reg_rdata, // read answer, valid one cycle after reg_rd
    output logic reg_rvalid,
    // measurement side: the adc hands over finished results, never the host
    input wire logic ch1_sample_valid, // adc delivers a new channel one result
    input wire logic [7:0] ch1_sample,
    input wire logic ch2_sample_valid,
    input wire logic [7:0] ch2_sample,
    // peak current settings, channel one then channel two
    output logic [1:0] ch1_peak_range_sel,
    output logic [7:0] ch1_peak_threshold,
    output logic [1:0] ch2_peak_range_sel,
    output logic [7:0] ch2_peak_threshold,
    // off-time versus led voltage constants
    output logic [4:0] ch1_off_time_const,
    output logic [4:0] ch2_off_time_const,
    // regulator control word
    output logic ch1_offset_cancel_disable,
    output logic ch2_offset_cancel_disable,
    output logic gate_slope_slow_enable,
    output logic [1:0] overcurrent_detect_setting,
    output logic [2:0] failsafe_mode_select,
    output logic ch1_regulator_enable,
    output logic ch2_regulator_enable,
    // thermal recovery and warning
    output logic ch1_thermal_auto_recover,
    output logic ch2_thermal_auto_recover,
    output logic [7:0] thermal_warn_threshold,
    // measurement setup, temperature trim and peak compensation
    output logic [8:0] led_measure_setting,
    output logic temp_adc_trim_parity,
    output logic [5:0] temp_adc_trim,
    output logic [6:0] ch1_peak_compensation,
    output logic [6:0] ch2_peak_compensation,
    // adc ranges and raw otp control bits
    output logic [1:0] ch1_led_adc_range,
    output logic [1:0] ch2_led_adc_range,
    output logic [5:0] otp_control // low six bits of register nine, passed on raw
);
    // ***************************************************************
    // storage
    // ***************************************************************
    // control words, written by the host only
    logic [9:0] ch1_peak_r; // channel one peak current word
    logic [9:0] ch2_peak_r; // channel two peak current word
    logic [9:0] off_time_r; // both off-time constants
    logic [9:0] reg_ctrl_r; // enables, offset cancel, slope, overcurrent, fail-safe
    logic [9:0] thermal_r; // auto recovery and warning threshold
    logic [9:0] led_meas_r; // measurement setting and trim parity
    logic [9:0] ch1_trim_r; // channel one compensation, low trim half
    logic [9:0] ch2_trim_r; // channel two compensation, high trim half
    logic [9:0] adc_otp_r; // adc ranges and otp control
    // status words, written by the adc only
    logic [9:0] ch1_vled_r; // status word incl. parity, set only by the adc
    logic [9:0] ch2_vled_r; // same for channel two
    // read path
    logic [9:0] rdata_nxt; // word picked by the address, before the answer flop

    // odd parity: bit eight makes the nine-bit group hold an odd count;
    // an all-zero sample therefore reads back with bit eight set
    // bit nine of a status word always reads zero
    function automatic logic [9:0] status_word(input logic [7:0] d);
        status_word = {1'b0, ~(^d), d};
    endfunction

    // write decode used by every control register; addresses outside the
    // control map, address zero included, match no target and fall away
    function automatic logic wr_hit(input logic wr, input logic [4:0] a,
                                    input logic [4:0] target);
        wr_hit = wr && (a == target);
    endfunction

    // ***************************************************************
    // control registers
    // ***************************************************************
    // one process per control word: each word is written whole, there is
    // no masked write, so a host that changes one field rewrites its
    // neighbours with the values it last wrote
    // channel one peak word: range select in the top two bits, comparator
    // threshold in the low byte
    always_ff @(posedge clk) begin
        if (rst) begin
            ch1_peak_r <= dbl_pkg::RST_ZERO;
        end else if (wr_hit(reg_wr, reg_addr, dbl_pkg::ADDR_CH1_PEAK)) begin
            ch1_peak_r <= reg_wdata;
        end
    end

    // channel two peak word, same layout as channel one
    always_ff @(posedge clk) begin
        if (rst) begin
            ch2_peak_r <= dbl_pkg::RST_ZERO;
        end else if (wr_hit(reg_wr, reg_addr, dbl_pkg::ADDR_CH2_PEAK)) begin
            ch2_peak_r <= reg_wdata;
        end
    end

    // off-time constants: channel one in the upper five bits, channel two
    // in the lower five
    always_ff @(posedge clk) begin
        if (rst) begin
            off_time_r <= dbl_pkg::RST_ZERO;
        end else if (wr_hit(reg_wr, reg_addr, dbl_pkg::ADDR_OFF_TIME)) begin
            off_time_r <= reg_wdata;
        end
    end

    // regulator control: both enables clear on reset, so the regulators
    // stay off until the host has set the other fields up
    always_ff @(posedge clk) begin
        if (rst) begin
            reg_ctrl_r <= dbl_pkg::RST_ZERO;
        end else if (wr_hit(reg_wr, reg_addr, dbl_pkg::ADDR_REG_CTRL)) begin
            reg_ctrl_r <= reg_wdata;
        end
    end

    // thermal control: the only control word with a non-zero reset value
    // (warning threshold preset, auto recovery off)
    always_ff @(posedge clk) begin
        if (rst) begin
            thermal_r <= dbl_pkg::RST_THERMAL;
        end else if (wr_hit(reg_wr, reg_addr, dbl_pkg::ADDR_THERMAL)) begin
            thermal_r <= reg_wdata;
        end
    end

    // measurement setup; bit nine is the trim parity, stored as written,
    // because checking it is the job of whoever uses the trim
    always_ff @(posedge clk) begin
        if (rst) begin
            led_meas_r <= dbl_pkg::RST_ZERO;
        end else if (wr_hit(reg_wr, reg_addr, dbl_pkg::ADDR_LED_MEAS)) begin
            led_meas_r <= reg_wdata;
        end
    end

    // channel one trim: compensation low, lower temperature trim half on top;
    // the halves only make sense together, so the host writes both words
    always_ff @(posedge clk) begin
        if (rst) begin
            ch1_trim_r <= dbl_pkg::RST_ZERO;
        end else if (wr_hit(reg_wr, reg_addr, dbl_pkg::ADDR_CH1_TRIM)) begin
            ch1_trim_r <= reg_wdata;
        end
    end

    // channel two trim: compensation low, upper temperature trim half
    // on top
    always_ff @(posedge clk) begin
        if (rst) begin
            ch2_trim_r <= dbl_pkg::RST_ZERO;
        end else if (wr_hit(reg_wr, reg_addr, dbl_pkg::ADDR_CH2_TRIM)) begin
            ch2_trim_r <= reg_wdata;
        end
    end

    // adc range selects and the raw otp control bits
    always_ff @(posedge clk) begin
        if (rst) begin
            adc_otp_r <= dbl_pkg::RST_ZERO;
        end else if (wr_hit(reg_wr, reg_addr, dbl_pkg::ADDR_ADC_OTP)) begin
            adc_otp_r <= reg_wdata;
        end
    end

    // ***************************************************************
    // status registers
    // ***************************************************************
    // only the adc strobes load these; host writes are not decoded here, so a
    // write and a fresh sample in one cycle never compete for the word
    // channel one measured led voltage
    always_ff @(posedge clk) begin
        if (rst) begin
            ch1_vled_r <= dbl_pkg::RST_VLED;
        end else if (ch1_sample_valid) begin
            ch1_vled_r <= status_word(ch1_sample);
        end
    end

    // channel two measured led voltage
    always_ff @(posedge clk) begin
        if (rst) begin
            ch2_vled_r <= dbl_pkg::RST_VLED;
        end else if (ch2_sample_valid) begin
            ch2_vled_r <= status_word(ch2_sample);
        end
    end

    // ***************************************************************
    // read mux
    // ***************************************************************
    // nop and unmapped addresses answer all zeros
    // a status word read in the cycle of a new sample shows the older value;
    // the new one is there from the next read on
    always_comb begin
        unique case (reg_addr)
            dbl_pkg::ADDR_CH1_PEAK: rdata_nxt = ch1_peak_r;
            dbl_pkg::ADDR_CH2_PEAK: rdata_nxt = ch2_peak_r;
            dbl_pkg::ADDR_OFF_TIME: rdata_nxt = off_time_r;
            dbl_pkg::ADDR_REG_CTRL: rdata_nxt = reg_ctrl_r;
            dbl_pkg::ADDR_THERMAL: rdata_nxt = thermal_r;
            dbl_pkg::ADDR_LED_MEAS: rdata_nxt = led_meas_r;
            dbl_pkg::ADDR_CH1_TRIM: rdata_nxt = ch1_trim_r;
            dbl_pkg::ADDR_CH2_TRIM: rdata_nxt = ch2_trim_r;
            dbl_pkg::ADDR_ADC_OTP: rdata_nxt = adc_otp_r;
            dbl_pkg::ADDR_CH1_VLED: rdata_nxt = ch1_vled_r;
            dbl_pkg::ADDR_CH2_VLED: rdata_nxt = ch2_vled_r;
            default: rdata_nxt = dbl_pkg::RST_ZERO;
        endcase
    end

    // registered answer so the front end sees a stable word; it is held
    // between reads because the serial side may shift it out slowly
    always_ff @(posedge clk) begin
        if (rst) begin
            reg_rdata <= dbl_pkg::RST_ZERO;
        end else if (reg_rd) begin
            reg_rdata <= rdata_nxt;
        end
    end

    // answer marker: one cycle after each read strobe, never stretched
    always_ff @(posedge clk) begin
        if (rst) begin
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
        end
    end

    // ***************************************************************
    // field outputs, straight from the storage flops
    // ***************************************************************
    // every output is a plain slice of a storage flop (temp_adc_trim joins two such slices), so it changes one
    // cycle after the write that sets it and never glitches in between
    // peak current words
    assign ch1_peak_range_sel = ch1_peak_r[dbl_pkg::PEAK_RANGE_LSB +: 2];
    assign ch1_peak_threshold = ch1_peak_r[7:0];
    assign ch2_peak_range_sel = ch2_peak_r[dbl_pkg::PEAK_RANGE_LSB +: 2];
    assign ch2_peak_threshold = ch2_peak_r[7:0];

    // off-time constants
    assign ch1_off_time_const = off_time_r[dbl_pkg::TOFF1_LSB +: 5];
    assign ch2_off_time_const = off_time_r[4:0];

    // regulator control word
    assign ch1_offset_cancel_disable = reg_ctrl_r[dbl_pkg::CTRL_OC1_BIT];
    assign ch2_offset_cancel_disable = reg_ctrl_r[dbl_pkg::CTRL_OC2_BIT];
    assign gate_slope_slow_enable = reg_ctrl_r[dbl_pkg::CTRL_SLOW_BIT];
    assign overcurrent_detect_setting = reg_ctrl_r[dbl_pkg::CTRL_OCD_LSB +: 2];
    assign failsafe_mode_select = reg_ctrl_r[dbl_pkg::CTRL_FSO_LSB +: 3];
    assign ch1_regulator_enable = reg_ctrl_r[dbl_pkg::CTRL_EN1_BIT];
    assign ch2_regulator_enable = reg_ctrl_r[dbl_pkg::CTRL_EN2_BIT];

    // thermal control word
    assign ch1_thermal_auto_recover = thermal_r[dbl_pkg::THERM_AR1_BIT];
    assign ch2_thermal_auto_recover = thermal_r[dbl_pkg::THERM_AR2_BIT];
    assign thermal_warn_threshold = thermal_r[7:0];

    // measurement setup; the trim parity is passed on, not checked here
    assign led_measure_setting = led_meas_r[8:0];
    assign temp_adc_trim_parity = led_meas_r[9];

    // trim halves: register seven low, register eight high
    assign temp_adc_trim = {ch2_trim_r[dbl_pkg::TRIM_HI_LSB +: 3],
                            ch1_trim_r[dbl_pkg::TRIM_HI_LSB +: 3]};
    assign ch1_peak_compensation = ch1_trim_r[6:0];
    assign ch2_peak_compensation = ch2_trim_r[6:0];

    // adc ranges
    assign ch1_led_adc_range = adc_otp_r[dbl_pkg::ADC1_RNG_LSB +: 2];
    assign ch2_led_adc_range = adc_otp_r[dbl_pkg::ADC2_RNG_LSB +: 2];

    // otp control bits are passed on raw; what they mean is decided by the
    // otp sequencer beside this block
    assign otp_control = adc_otp_r[5:0];
endmodule
`default_nettype wire

//--- verif/dbl_regs_properties.sv
`timescale 1ns/1ns
`default_nettype none
module dbl_regs_chk (
    input wire logic clk,
    input wire logic rst,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [4:0] reg_addr,
    input wire logic [9:0] reg_wdata,
    input wire logic [9:0] reg_rdata,
    input wire logic reg_rvalid
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // a read answers exactly one cycle later and the answer then holds
    read_answer_a: assert property (reg_rd |=> reg_rvalid) else $error("no answer");
    rvalid_pulse_a: assert property (!reg_rd |=> !reg_rvalid) else $error("stray");
    rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata)) else $error("moved");
    nop_read_a: assert property (reg_rd && reg_addr == 5'h00 |=> reg_rdata == 10'h000)
        else $error("nop read");
    unmapped_read_a: assert property (reg_rd && reg_addr > 5'h0b |=> reg_rdata == 10'h000)
        else $error("unmapped read");
    // status words: odd parity in bit 8, top bit always clear
    status_parity_a: assert property (reg_rd && reg_addr inside {5'h0a, 5'h0b} |=>
        reg_rdata[8] == ~^reg_rdata[7:0]) else $error("parity");
    status_top_a: assert property (reg_rd && reg_addr inside {5'h0a, 5'h0b} |=>
        !reg_rdata[9]) else $error("top bit");
    // the write, one idle cycle, then the read of the same word
    peak_readback_a: assert property (reg_wr && reg_addr == 5'h01 ##1 !reg_wr ##1
        reg_rd && reg_addr == 5'h01 |=> reg_rdata == $past(reg_wdata, 3)) else $error("peak");
    cover property (reg_wr && reg_rd);
    cover property (reg_rd && reg_addr == 5'h0a);
    cover property (reg_wr && reg_addr == 5'h0b);
endmodule
bind dbl_config_regs dbl_regs_chk i_dbl_regs_chk (.clk, .rst, .reg_wr, .reg_rd, .reg_addr,
    .reg_wdata, .reg_rdata, .reg_rvalid);
`default_nettype wire

//--- verif/dbl_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module dbl_host_model (
    input wire logic clk,
    input wire logic reg_rvalid,
    input wire logic [9:0] reg_rdata,
    output logic reg_wr,
    output logic reg_rd,
    output logic [4:0] reg_addr,
    output logic [9:0] reg_wdata
);
    initial {reg_wr, reg_rd, reg_addr, reg_wdata} = 17'h00000;
    // strobes stand for one edge; released lines carry the inverted word, never a stale one
    task automatic acc(input logic w, r, input logic [4:0] a, input logic [9:0] d,
            output logic [9:0] q, output logic ok);
        @(negedge clk);
        {reg_wr, reg_rd, reg_addr, reg_wdata} = {w, r, a, d};
        @(negedge clk);
        {reg_wr, reg_rd, reg_addr, reg_wdata} = {2'h0, ~a, ~d};
        for (int n = 0; n < 4 && r && reg_rvalid !== 1'b1; n++) @(negedge clk);
        q = reg_rdata;
        ok = !r || reg_rvalid === 1'b1;
    endtask
endmodule
`default_nettype wire

//--- verif/dual_buck_led_config_regs_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
// ********
// register bank bench
// ********
module dual_buck_led_config_regs_tb_top;
    logic clk = 1'b0, rst = 1'b1;
    logic reg_wr, reg_rd, reg_rvalid, ok;
    logic [4:0] reg_addr, a;
    logic [9:0] reg_wdata, reg_rdata, q, rv, wd;
    logic v1 = 1'b0, v2 = 1'b0; // adc result strobes
    logic [7:0] s1 = 8'h00, s2 = 8'h00;
    wire [9:0] img [1:9]; // field outputs folded back into register words
    int fails = 0, tests_run = 0;
    logic [24:0] rows [13] = '{{5'h00, 10'h000, 10'h3ff}, {5'h01, 10'h000, 10'h2a5},
        {5'h02, 10'h000, 10'h15a}, {5'h03, 10'h000, 10'h3e1}, {5'h04, 10'h000, 10'h2b6},
        {5'h05, 10'h0b3, 10'h1c4}, {5'h06, 10'h000, 10'h3ff}, {5'h07, 10'h000, 10'h281},
        {5'h08, 10'h000, 10'h17e}, {5'h09, 10'h000, 10'h2c3}, {5'h0a, 10'h100, 10'h0ff},
        {5'h0b, 10'h100, 10'h2aa}, {5'h1f, 10'h000, 10'h3ff}}; // address, reset, write
    always #5 clk = ~clk;
    dbl_host_model i_dbl_host_model (.clk, .reg_rvalid, .reg_rdata, .reg_wr, .reg_rd,
        .reg_addr, .reg_wdata);
    dbl_config_regs i_dbl_config_regs (.clk, .rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
        .reg_rdata, .reg_rvalid, .ch1_sample_valid(v1), .ch1_sample(s1), .ch2_sample_valid(v2),
        .ch2_sample(s2), .ch1_peak_range_sel(img[1][9:8]), .ch1_peak_threshold(img[1][7:0]),
        .ch2_peak_range_sel(img[2][9:8]), .ch2_peak_threshold(img[2][7:0]),
        .ch1_off_time_const(img[3][9:5]), .ch2_off_time_const(img[3][4:0]),
        .ch1_offset_cancel_disable(img[4][9]), .ch2_offset_cancel_disable(img[4][8]),
        .gate_slope_slow_enable(img[4][7]), .overcurrent_detect_setting(img[4][6:5]),
        .failsafe_mode_select(img[4][4:2]), .ch1_regulator_enable(img[4][1]),
        .ch2_regulator_enable(img[4][0]), .ch1_thermal_auto_recover(img[5][9]),
        .ch2_thermal_auto_recover(img[5][8]), .thermal_warn_threshold(img[5][7:0]),
        .led_measure_setting(img[6][8:0]), .temp_adc_trim_parity(img[6][9]),
        .temp_adc_trim({img[8][9:7], img[7][9:7]}), .ch1_peak_compensation(img[7][6:0]),
        .ch2_peak_compensation(img[8][6:0]), .ch1_led_adc_range(img[9][9:8]),
        .ch2_led_adc_range(img[9][7:6]), .otp_control(img[9][5:0]));
    task automatic check(input logic [15:0] seen, exp, input string what);
        tests_run++;
        if (seen !== exp) begin
            $display("wrong value %s expected %h seen %h", what, exp, seen);
            fails++;
        end
    endtask
    // a bus access whose answer never comes ends the run
    task automatic bus(input logic w, r, input logic [4:0] ad, input logic [9:0] d);
        i_dbl_host_model.acc(w, r, ad, d, q, ok);
        check(ok, 1'b1, "bus answer");
        if (!ok) complete_run();
    endtask
    task automatic complete_run;
        if (fails == 0 && tests_run > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        repeat (16) @(negedge clk);
        rst = 1'b0;
        foreach (rows[i]) begin
            {a, rv, wd} = rows[i];
            bus(1'b0, 1'b1, a, 10'h000);
            check(q, rv, "reset value");
            bus(1'b1, 1'b0, a, wd);
            bus(1'b0, 1'b1, a, 10'h000);
            check(q, (a inside {[5'h01:5'h09]}) ? wd : rv, "read back");
            if (a inside {[5'h01:5'h09]}) check(img[a], wd, "fields");
        end
        @(negedge clk);
        {v1, v2, s1, s2} = {2'h3, 8'h5a, 8'h07};
        @(negedge clk);
        {v1, v2, s1, s2} = {2'h0, 8'ha5, 8'hf8};
        bus(1'b0, 1'b1, 5'h0a, 10'h000);
        check(q, 10'h15a, "adc one");
        bus(1'b0, 1'b1, 5'h0b, 10'h000);
        check(q, 10'h007, "adc two");
        bus(1'b1, 1'b1, 5'h01, 10'h0f0);
        check(q, 10'h2a5, "read during write");
        check(img[1], 10'h0f0, "write beside read");
        // reset again in mid-run: peak one, control, thermal and both status words must fall back to their reset values
        @(negedge clk);
        rst = 1'b1;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        check(reg_rvalid, 1'b0, "valid after reset");
        check(reg_rdata, 10'h000, "data after reset");
        check(img[1], 10'h000, "peak after reset");
        check(img[4], 10'h000, "enables after reset");
        check(img[5], 10'h0b3, "thermal after reset");
        bus(1'b0, 1'b1, 5'h0a, 10'h000);
        check(q, 10'h100, "status one after reset");
        bus(1'b0, 1'b1, 5'h0b, 10'h000);
        check(q, 10'h100, "status two after reset");
        complete_run();
    end
endmodule
`default_nettype wire
